// ==== core/sec_status_cfg.svh ====
// Offsets, field positions and fixed values of the secondary status and bridge control registers
`ifndef SEC_STATUS_CFG_SVH
`define SEC_STATUS_CFG_SVH
`define SEC_STATUS_OFFSET      8'h1E
`define BRIDGE_CTRL_OFFSET     8'h3E
`define BIT_PARITY_RESP_EN     0
`define BIT_DETECTED_PARITY    15
`define BIT_SYSTEM_ERROR       14
`define BIT_MASTER_ABORT       13
`define BIT_TARGET_ABORT_RX    12
`define BIT_TARGET_ABORT_SIG   11
`define DECODE_TIMING_HI       10
`define DECODE_TIMING_LO       9
`define DECODE_TIMING_VALUE    2'h1
`define BIT_MASTER_DATA_PARITY 8
`define BIT_FAST_B2B           7
`define BIT_SPEED_66           5
`define EVENT_MASK             16'hF900
`define SEC_STATUS_RESET       16'h0280
`endif

// ==== core/sec_status_pkg.sv ====
// Types shared by the secondary status register
package sec_status_pkg;
   typedef struct packed {
      logic addr_attr_err_as_target;
      logic data_err_write_target;
      logic data_err_read_master;
      logic serr_seen;
      logic master_abort;
      logic target_abort_rx;
      logic target_abort_sig;
      logic master_perr_read;
      logic master_perr_write;
   } sec_events_t;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [1:0]  be;
   } cfg_req_t;
endpackage : sec_status_pkg

// ==== core/pin_sync.sv ====
// Two-stage synchroniser for a level arriving on a pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic clk_en,
   input  wire logic pin,
   output var  logic level
);
   logic stage1;
   // First stage feeds the second stage only
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= 1'b0;
         level  <= 1'b0;
      end else if (clk_en) begin
         stage1 <= pin;
         level  <= stage1;
      end
   end
endmodule : pin_sync
`default_nettype wire

// ==== core/secondary_bus_status.sv ====
// Secondary bus status register with its event capture logic
`timescale 1ns/1ps
`default_nettype none
`include "sec_status_cfg.svh"
module secondary_bus_status
   import sec_status_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire cfg_req_t    cfg_req,
   input  wire sec_events_t events,
   input  wire logic        parity_response_enable,
   input  wire logic        sixty_six_enable_pin,
   output var  logic [15:0] cfg_rdata,
   output var  logic        cfg_rvalid,
   output var  logic [15:0] status
);
   logic        speed_66_capable;
   logic        hit;
   logic        parity_event;
   logic        perr_event;
   logic        detected_parity_error;
   logic        system_error_received;
   logic        master_abort_received;
   logic        target_abort_received;
   logic        target_abort_signaled;
   logic        master_data_parity_error;
   logic [15:0] clr;
   logic [15:0] next_status;

   // Pin is asynchronous to the core clock
   pin_sync u_m66 (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .pin      (sixty_six_enable_pin),
      .level    (speed_66_capable)
   );

   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // Set term ORed last so a same-cycle event survives the clear
   function automatic logic hold_or_set(input logic cur,
                                        input logic clear,
                                        input logic set);
      hold_or_set = (cur & ~clear) | set;
   endfunction : hold_or_set

   assign hit = (cfg_req.addr == `SEC_STATUS_OFFSET);
   // Only event bits can be cleared; read-only bits ignore writes
   assign clr = (cfg_req.wr && hit) ?
                (cfg_req.wdata & lane_mask(cfg_req.be) & `EVENT_MASK)
                : 16'h0000;

   // Address, write-target and read-master parity errors set bit 15, whatever the response enable says
   assign parity_event = events.addr_attr_err_as_target
                         | events.data_err_write_target
                         | events.data_err_read_master;
   // Master parity counts only with the response enable set
   assign perr_event = parity_response_enable
                       & (events.master_perr_read
                          | events.master_perr_write);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         detected_parity_error <= 1'b0;
      end else if (clk_en) begin
         detected_parity_error <= hold_or_set(detected_parity_error,
            clr[`BIT_DETECTED_PARITY], parity_event);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         system_error_received <= 1'b0;
      end else if (clk_en) begin
         system_error_received <= hold_or_set(system_error_received,
            clr[`BIT_SYSTEM_ERROR], events.serr_seen);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         master_abort_received <= 1'b0;
      end else if (clk_en) begin
         master_abort_received <= hold_or_set(master_abort_received,
            clr[`BIT_MASTER_ABORT], events.master_abort);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         target_abort_received <= 1'b0;
      end else if (clk_en) begin
         target_abort_received <= hold_or_set(target_abort_received,
            clr[`BIT_TARGET_ABORT_RX], events.target_abort_rx);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         target_abort_signaled <= 1'b0;
      end else if (clk_en) begin
         target_abort_signaled <= hold_or_set(target_abort_signaled,
            clr[`BIT_TARGET_ABORT_SIG], events.target_abort_sig);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         master_data_parity_error <= 1'b0;
      end else if (clk_en) begin
         master_data_parity_error <= hold_or_set(master_data_parity_error,
            clr[`BIT_MASTER_DATA_PARITY], perr_event);
      end
   end

   always_comb begin
      next_status = 16'h0000;
      next_status[`BIT_DETECTED_PARITY]  = detected_parity_error;
      next_status[`BIT_SYSTEM_ERROR]     = system_error_received;
      next_status[`BIT_MASTER_ABORT]     = master_abort_received;
      next_status[`BIT_TARGET_ABORT_RX]  = target_abort_received;
      next_status[`BIT_TARGET_ABORT_SIG] = target_abort_signaled;
      next_status[`DECODE_TIMING_HI:`DECODE_TIMING_LO] =
         `DECODE_TIMING_VALUE;
      next_status[`BIT_MASTER_DATA_PARITY] = master_data_parity_error;
      next_status[`BIT_FAST_B2B] = 1'b1;
      next_status[`BIT_SPEED_66] = speed_66_capable;
   end

   // Registered view; one cycle behind the sticky bits
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         status <= `SEC_STATUS_RESET;
      end else if (clk_en) begin
         status <= next_status;
      end
   end

   // Every read is answered, whatever its offset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rvalid <= 1'b0;
      end else if (clk_en) begin
         cfg_rvalid <= cfg_req.rd;
      end
   end

   // Read returns the live view the cycle after the request
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_rdata <= 16'h0000;
      end else if (clk_en) begin
         cfg_rdata <= (cfg_req.rd && hit) ? next_status : 16'h0000;
      end
   end

   AST_SERR_SETS: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && events.serr_seen |=> system_error_received)
      else $error("serr did not set bit 14");
   AST_PARITY_SETS: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && (events.addr_attr_err_as_target
      || events.data_err_write_target || events.data_err_read_master)
      |=> detected_parity_error)
      else $error("parity event did not set bit 15");
   AST_MASTER_ABORT_RECEIVED: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && events.master_abort |=> ##1 status[13] || !clk_en)
      else $error("master abort not shown");
   AST_TABORT_RX: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && events.target_abort_rx |=> target_abort_received)
      else $error("target abort rx lost");
   AST_TARGET_ABORT_SIGNALED: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && events.target_abort_sig |=> target_abort_signaled)
      else $error("target abort sig lost");
   AST_DPAR_GATED: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && !parity_response_enable && !master_data_parity_error
      |=> !master_data_parity_error)
      else $error("bit 8 set without enable");
   AST_DPAR_SETS: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && parity_response_enable
      && (events.master_perr_read || events.master_perr_write)
      |=> master_data_parity_error)
      else $error("enabled master parity did not set bit 8");
   AST_FIXED_BITS: assert property (
      @(posedge core_clk) disable iff (!rstn)
      status[10:9] == 2'h1 && status[7] == 1'b1 && status[6] == 1'b0)
      else $error("fixed bits wrong");
   AST_RSVD_LOW: assert property (
      @(posedge core_clk) disable iff (!rstn)
      status[4:0] == 5'h00)
      else $error("reserved bits nonzero");
   AST_SPEED_PIN: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en |=> status[5] == $past(speed_66_capable))
      else $error("bit 5 does not follow the pin");
   AST_CLEAR: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && clr[14] && !events.serr_seen |=> !system_error_received)
      else $error("write one did not clear");
   AST_EVENT_HOLD: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && clr == 16'h0000
      |=> ($past(next_status) & ~next_status & `EVENT_MASK) == 16'h0000)
      else $error("event bit dropped without a clear");
   AST_FROZEN: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !clk_en |=> $stable(status) && $stable(next_status))
      else $error("state moved while enable low");
   AST_READ_ANSWER: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && cfg_req.rd |=> cfg_rvalid)
      else $error("read not answered");
   AST_READ_MISS: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && cfg_req.rd && cfg_req.addr != `SEC_STATUS_OFFSET
      |=> cfg_rdata == 16'h0000)
      else $error("other offset read nonzero");
   AST_READ_FIXED: assert property (
      @(posedge core_clk) disable iff (!rstn)
      clk_en && cfg_req.rd && hit
      |=> cfg_rdata[10:9] == 2'h1 && cfg_rdata[7] == 1'b1
      && cfg_rdata[6] == 1'b0 && cfg_rdata[4:0] == 5'h00)
      else $error("read data fixed bits wrong");
endmodule : secondary_bus_status
`default_nettype wire

// ==== dv/sec_agent.sv ====
// Secondary bus agent model raising event pulses
`timescale 1ns/1ps
`default_nettype none
module sec_agent
   import sec_status_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        fire,
   input  wire logic [3:0]  which,
   output var  sec_events_t events
);
   // One-cycle pulses, one event kind at a time
   always_ff @(posedge core_clk) begin
      events <= fire ? sec_events_t'(9'h100 >> which) : '0;
   end
endmodule : sec_agent
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the secondary status register
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sec_status_pkg::*;
   logic        core_clk, rstn, pre, pin, fire, cfg_rvalid;
   logic        ce;
   logic [3:0]  which;
   cfg_req_t    cfg_req;
   sec_events_t events;
   logic [15:0] cfg_rdata, status;
   int          n_mismatch = 0, num_checks = 0, cyc = 0;
   logic [15:0] ev_bit [9] = '{16'h8000, 16'h8000, 16'h8000, 16'h4000,
      16'h2000, 16'h1000, 16'h0800, 16'h0100, 16'h0100};
   secondary_bus_status i_dut (.core_clk(core_clk), .rstn(rstn),
      .clk_en(ce), .cfg_req(cfg_req), .events(events),
      .parity_response_enable(pre), .sixty_six_enable_pin(pin),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .status(status));
   sec_agent i_agent (.core_clk(core_clk), .fire(fire), .which(which),
      .events(events));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task print_verdict();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk) cfg_req <= '{1'b1, 1'b0, a, 16'h0000, 2'h0};
      @(posedge core_clk) cfg_req <= '0;
      #1 chk({15'h0000, cfg_rvalid}, 16'h0001);
      chk(cfg_rdata, exp);
   endtask : rd
   task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
      @(posedge core_clk) cfg_req <= '{1'b0, 1'b1, a, d, be};
      @(posedge core_clk) cfg_req <= '0;
   endtask : wr
   task ev(input int k, input logic p);
      @(posedge core_clk) begin
         pre <= p;
         which <= k[3:0];
         fire <= 1'b1;
      end
      @(posedge core_clk) fire <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : ev
   initial begin
      rstn = 1'b0;
      pre = 1'b0;
      pin = 1'b1;
      fire = 1'b0;
      which = 4'h0;
      cfg_req = '0;
      ce = 1'b1;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      // Pin level needs the synchroniser to settle
      repeat (4) @(posedge core_clk);
      rd(8'h1E, 16'h02A0);
      chk(status, 16'h02A0);
      for (int k = 0; k < 9; k++) begin
         ev(k, 1'b1);
         rd(8'h1E, 16'h02A0 | ev_bit[k]);
         chk(status, 16'h02A0 | ev_bit[k]);
         wr(8'h1E, 16'h0000, 2'h3);
         rd(8'h1E, 16'h02A0 | ev_bit[k]);
         wr(8'h1E, ev_bit[k], 2'h1);
         rd(8'h1E, 16'h02A0 | ev_bit[k]);
         wr(8'h1E, ev_bit[k], 2'h2);
         rd(8'h1E, 16'h02A0);
      end
      for (int k = 7; k < 9; k++) begin
         ev(k, 1'b0);
         rd(8'h1E, 16'h02A0);
      end
      ev(0, 1'b0);
      rd(8'h1E, 16'h82A0);
      wr(8'h1E, 16'hFFFF, 2'h3);
      rd(8'h1E, 16'h02A0);
      ev(3, 1'b1);
      // Clears aimed at a neighbour register must not land here
      wr(8'h1C, 16'h4000, 2'h3);
      rd(8'h1E, 16'h42A0);
      rd(8'h1C, 16'h0000);
      // A clear while the enable is low must be ignored
      @(posedge core_clk) ce <= 1'b0;
      wr(8'h1E, 16'h4000, 2'h3);
      @(posedge core_clk) ce <= 1'b1;
      rd(8'h1E, 16'h42A0);
      @(posedge core_clk) pin <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(8'h1E, 16'h4280);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
